// ### verilog/scim_pkg.sv
`default_nettype none
package scim_pkg;
	// Register offsets, one 32-bit aligned word each
	localparam logic [5:0] OFS_MODE = 6'h00;
	localparam logic [5:0] OFS_DATA = 6'h04;
	localparam logic [5:0] OFS_RATE_LIN = 6'h08;
	localparam logic [5:0] OFS_RATE_EXP = 6'h0C;
	localparam logic [5:0] OFS_CMD = 6'h10;
	localparam logic [5:0] OFS_ACK_CTRL = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_EVENTS = 6'h1C;
	localparam logic [5:0] OFS_EVT_MASK = 6'h20;
	// Mode field values
	localparam logic [1:0] MODE_DISABLED = 2'h0;
	localparam logic [1:0] MODE_TWOWIRE = 2'h3;
	// Reset values
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [3:0] RST_RATE_LIN = 4'h0;
	localparam logic [3:0] RST_RATE_EXP = 4'h0;
	localparam logic RST_ACK_SEL = 1'b0;
	localparam logic [5:0] RST_EVT_MASK = 6'h00;
	// Status register field positions
	localparam int ST_NACK_POS = 0;
	localparam int ST_TXFIN_POS = 1;
	localparam int ST_RXFIN_POS = 2;
	localparam int ST_CMDFIN_POS = 3;
	// Last half-period step of each segment; bit index of the acknowledge
	localparam logic [4:0] START_LAST = 5'h03;
	localparam logic [4:0] BYTE_LAST = 5'h11;
	localparam logic [4:0] STOP_LAST = 5'h02;
	localparam logic [3:0] ACK_BIT = 4'h8;
	// Segment sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BYTE, ST_STOP} scim_state_e;
	// Segment command bits, start in bit 0
	typedef struct packed {
		logic stop;
		logic recv;
		logic send;
		logic start;
	} scim_cmd_s;
	// Sticky event bits, cmdfin in bit 0
	typedef struct packed {
		logic underrun;
		logic overrun;
		logic nack;
		logic rxfin;
		logic txfin;
		logic cmdfin;
	} scim_evt_s;
endpackage : scim_pkg
`default_nettype wire

// ### verilog/scim_i2c_master.sv
// Functional notes
// - Two-wire master only, active only when mode field equals 3.
// - No arbitration; the device assumes it is the only master.
// - Lines are only pulled low or released, never driven high.
// - Bus rate is reference divided by 2*(linear+1)*2^exponent.
// - Only one segment command bit at a time; others are illegal.
// - Receive segment answers ACK or NACK from the ack select bit.
// - One-byte transmit and receive buffers through the data register.
// - Start/stop bit clears when done and sets the condition flag.
// - Transmit bit clears when done and sets the transmit flag.
// - Receive bit clears when the byte completes; receive flag set in the same cycle.
// - After each sent byte a status bit records ACK or NACK.
// - Events on condition, transmit, receive completion and NACK.
// - Byte arriving with receive buffer full flags overrun, is lost.
// - Sending with empty transmit buffer flags underrun.
// - Events reach the processor only if both masks allow it.
// - Mode 0 off, 1 UART, 2 SPI, 3 two-wire; disable before switch.
`default_nettype none
module scim_i2c_master
	import scim_pkg::*;
#(
	parameter int DIV_W = 20
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic top_irq_en,
	output logic irq,
	input wire logic master_serial_clock_pin_i,
	output logic master_serial_clock_pin_o,
	output logic master_serial_clock_pin_oe,
	input wire logic master_serial_data_pin_i,
	output logic master_serial_data_pin_o,
	output logic master_serial_data_pin_oe
);
	logic [1:0] serial_ctrl_mode_select;
	logic [3:0] bus_rate_linear;
	logic [3:0] bus_rate_exponent;
	logic ack_select;
	logic ack_latched;
	scim_cmd_s cmd;
	scim_evt_s events;
	scim_evt_s evt_mask;
	scim_evt_s evt_set;
	scim_state_e state;
	logic [4:0] step;
	logic [DIV_W-1:0] div_cnt;
	logic [DIV_W-1:0] div_limit;
	logic [7:0] shift;
	logic sending;
	logic [7:0] tx_buf;
	logic tx_full;
	logic [7:0] rx_buf;
	logic rx_full;
	logic nack_seen;
	logic transmit_done_flag;
	logic receive_done_flag;
	logic condition_done_flag;
	logic [31:0] rd_val;
	logic commit, wr, rd, enabled, tick, launch;
	logic start_done, byte_done, stop_done;
	logic [3:0] bit_idx;

	// Bus commit happens at the edge where the master sees ack
	assign commit = wb_cyc_i && wb_stb_i && wb_ack_o;
	assign wr = commit && wb_we_i && wb_sel_i[0];
	assign rd = commit && !wb_we_i;
	assign enabled = (serial_ctrl_mode_select == MODE_TWOWIRE);
	assign bit_idx = step[4:1];

	// Half-period divider limit; reference is clk
	always_comb begin
		div_limit = DIV_W'((DIV_W'(bus_rate_linear) + DIV_W'(1))
			<< bus_rate_exponent) - DIV_W'(1);
	end

	assign tick = (state != ST_IDLE) && (div_cnt == div_limit);
	assign start_done = tick && state == ST_START && step == START_LAST;
	assign byte_done = tick && state == ST_BYTE && step == BYTE_LAST;
	assign stop_done = tick && state == ST_STOP && step == STOP_LAST;
	// One command bit, no write pending; sole master, so no bus-free wait
	assign launch = enabled && state == ST_IDLE && $onehot(cmd)
		&& !(wr && wb_adr_i == OFS_CMD);

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		if (wb_adr_i == OFS_MODE) begin
			rd_val[1:0] = serial_ctrl_mode_select;
		end else if (wb_adr_i == OFS_DATA) begin
			rd_val[7:0] = rx_buf;
		end else if (wb_adr_i == OFS_RATE_LIN) begin
			rd_val[3:0] = bus_rate_linear;
		end else if (wb_adr_i == OFS_RATE_EXP) begin
			rd_val[3:0] = bus_rate_exponent;
		end else if (wb_adr_i == OFS_CMD) begin
			rd_val[3:0] = cmd;
		end else if (wb_adr_i == OFS_ACK_CTRL) begin
			rd_val[0] = ack_select;
		end else if (wb_adr_i == OFS_STATUS) begin
			rd_val[ST_NACK_POS] = nack_seen;
			rd_val[ST_TXFIN_POS] = transmit_done_flag;
			rd_val[ST_RXFIN_POS] = receive_done_flag;
			rd_val[ST_CMDFIN_POS] = condition_done_flag;
		end else if (wb_adr_i == OFS_EVENTS) begin
			rd_val[5:0] = events;
		end else if (wb_adr_i == OFS_EVT_MASK) begin
			rd_val[5:0] = evt_mask;
		end
	end

	// Wishbone slave: ack one cycle after the request, then drop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else if (ce) begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= rd_val;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			serial_ctrl_mode_select <= RST_MODE;
			bus_rate_linear <= RST_RATE_LIN;
			bus_rate_exponent <= RST_RATE_EXP;
			ack_select <= RST_ACK_SEL;
			evt_mask <= RST_EVT_MASK;
		end else if (ce && wr) begin
			if (wb_adr_i == OFS_MODE) begin
				serial_ctrl_mode_select <= wb_dat_i[1:0];
			end else if (wb_adr_i == OFS_RATE_LIN) begin
				bus_rate_linear <= wb_dat_i[3:0];
			end else if (wb_adr_i == OFS_RATE_EXP) begin
				bus_rate_exponent <= wb_dat_i[3:0];
			end else if (wb_adr_i == OFS_ACK_CTRL) begin
				ack_select <= wb_dat_i[0];
			end else if (wb_adr_i == OFS_EVT_MASK) begin
				evt_mask <= wb_dat_i[5:0];
			end
		end
	end

	// Segment sequencer; SCL is held where a segment leaves it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			step <= 5'h00;
			div_cnt <= '0;
			cmd <= '0;
			shift <= 8'h00;
			sending <= 1'b0;
			ack_latched <= 1'b0;
			master_serial_clock_pin_oe <= 1'b0;
			master_serial_data_pin_oe <= 1'b0;
		end else if (ce) begin
			if (!enabled) begin
				// Leaving the mode aborts and frees the bus
				state <= ST_IDLE;
				cmd <= '0;
				master_serial_clock_pin_oe <= 1'b0;
				master_serial_data_pin_oe <= 1'b0;
			end else if (state == ST_IDLE) begin
				if (wr && wb_adr_i == OFS_CMD) begin
					cmd <= wb_dat_i[3:0];
				end else if (launch) begin
					step <= 5'h00;
					div_cnt <= '0;
					ack_latched <= ack_select;
					if (cmd.start) begin
						state <= ST_START;
						master_serial_data_pin_oe <= 1'b0;
					end else if (cmd.stop) begin
						state <= ST_STOP;
						master_serial_clock_pin_oe <= 1'b1;
						master_serial_data_pin_oe <= 1'b1;
					end else begin
						state <= ST_BYTE;
						sending <= cmd.send;
						shift <= tx_buf;
						master_serial_clock_pin_oe <= 1'b1;
						master_serial_data_pin_oe <= cmd.send && !tx_buf[7];
					end
				end
			end else if (!tick) begin
				div_cnt <= div_cnt + DIV_W'(1);
			end else begin
				div_cnt <= '0;
				step <= step + 5'h01;
				case (state)
					ST_START: begin
						// Release SCL, pull SDA while high, then pull SCL
						if (step == 5'h00) begin
							master_serial_clock_pin_oe <= 1'b0;
						end else if (step == 5'h01) begin
							master_serial_data_pin_oe <= 1'b1;
						end else if (step == 5'h02) begin
							master_serial_clock_pin_oe <= 1'b1;
						end else begin
							state <= ST_IDLE;
							cmd.start <= 1'b0;
						end
					end
					ST_BYTE: begin
						if (step == BYTE_LAST) begin
							// Pull SCL and hold it; SDA only moves at next launch
							state <= ST_IDLE;
							master_serial_clock_pin_oe <= 1'b1;
							cmd.send <= 1'b0;
							cmd.recv <= 1'b0;
						end else if (!step[0]) begin
							master_serial_clock_pin_oe <= 1'b0;
						end else begin
							// Sample at end of high half, then drive next bit
							master_serial_clock_pin_oe <= 1'b1;
							if (bit_idx < ACK_BIT) begin
								shift <= {shift[6:0], master_serial_data_pin_i};
							end
							if (bit_idx + 4'h1 == ACK_BIT) begin
								master_serial_data_pin_oe <= !sending
									&& ack_latched;
							end else begin
								master_serial_data_pin_oe <= sending
									&& !shift[6];
							end
						end
					end
					ST_STOP: begin
						if (step == 5'h00) begin
							master_serial_clock_pin_oe <= 1'b0;
						end else if (step == 5'h01) begin
							master_serial_data_pin_oe <= 1'b0;
						end else begin
							state <= ST_IDLE;
							cmd.stop <= 1'b0;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Output levels are always low; only the enables move
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			master_serial_clock_pin_o <= 1'b0;
			master_serial_data_pin_o <= 1'b0;
		end else if (ce) begin
			master_serial_clock_pin_o <= 1'b0;
			master_serial_data_pin_o <= 1'b0;
		end
	end

	// One-byte buffers serviced by software only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_buf <= 8'h00;
			tx_full <= 1'b0;
			rx_buf <= 8'h00;
			rx_full <= 1'b0;
		end else if (ce) begin
			if (wr && wb_adr_i == OFS_DATA) begin
				tx_buf <= wb_dat_i[7:0];
				tx_full <= 1'b1;
			end else if (launch && cmd.send) begin
				tx_full <= 1'b0;
			end
			// A read that meets a completing byte still loses the new byte
			if (byte_done && !sending && !rx_full) begin
				rx_buf <= shift;
				rx_full <= 1'b1;
			end else if (rd && wb_adr_i == OFS_DATA) begin
				rx_full <= 1'b0;
			end
		end
	end

	// Completion flags clear when a segment of their kind is launched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			condition_done_flag <= 1'b0;
			transmit_done_flag <= 1'b0;
			receive_done_flag <= 1'b0;
			nack_seen <= 1'b0;
		end else if (ce) begin
			if (start_done || stop_done) begin
				condition_done_flag <= 1'b1;
			end else if (launch && (cmd.start || cmd.stop)) begin
				condition_done_flag <= 1'b0;
			end
			if (byte_done && sending) begin
				transmit_done_flag <= 1'b1;
				nack_seen <= master_serial_data_pin_i;
			end else if (launch && cmd.send) begin
				transmit_done_flag <= 1'b0;
			end
			if (byte_done && !sending) begin
				receive_done_flag <= 1'b1;
			end else if (launch && cmd.recv) begin
				receive_done_flag <= 1'b0;
			end
		end
	end

	// Event sources; completions are the flags' rising edges
	always_comb begin
		evt_set.cmdfin = start_done || stop_done;
		evt_set.txfin = byte_done && sending;
		evt_set.rxfin = byte_done && !sending;
		evt_set.nack = byte_done && sending
			&& master_serial_data_pin_i;
		evt_set.overrun = byte_done && !sending && rx_full;
		evt_set.underrun = launch && cmd.send && !tx_full;
	end

	// Sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			events <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wr && wb_adr_i == OFS_EVENTS) begin
				events <= (events & ~scim_evt_s'(wb_dat_i[5:0])) | evt_set;
			end else begin
				events <= events | evt_set;
			end
			irq <= top_irq_en && |(events & evt_mask);
		end
	end

	a_mode_gates_seq: assert property (@(posedge clk) disable iff (!nrst)
		!enabled |=> state == ST_IDLE)
		else $error("sequencer active outside two-wire mode");
	a_lines_never_high: assert property (@(posedge clk) disable iff (!nrst)
		!master_serial_clock_pin_o && !master_serial_data_pin_o)
		else $error("a bus line drives high");
	a_div_tick_limit: assert property (@(posedge clk) disable iff (!nrst)
		(ce && state != ST_IDLE && !tick) |=> div_cnt <= div_limit)
		else $error("divider passed its limit");
	a_illegal_cmd_ignored: assert property (@(posedge clk) disable iff (!nrst)
		(ce && state == ST_IDLE && !$onehot(cmd)) |=> state == ST_IDLE)
		else $error("illegal command combination launched");
	a_ack_bit_level: assert property (@(posedge clk) disable iff (!nrst)
		(state == ST_BYTE && !sending && bit_idx == ACK_BIT && step[0])
		|-> master_serial_data_pin_oe == ack_latched)
		else $error("wrong acknowledge driven");
	a_cond_fin_flag: assert property (@(posedge clk) disable iff (!nrst)
		(ce && (start_done || stop_done)) |=> condition_done_flag
		&& !cmd.start && !cmd.stop)
		else $error("condition completion not reported");
	a_tx_fin_flag: assert property (@(posedge clk) disable iff (!nrst)
		(ce && byte_done && sending) |=> transmit_done_flag && !cmd.send
		&& events.txfin)
		else $error("transmit completion not reported");
	a_rx_fin_flag: assert property (@(posedge clk) disable iff (!nrst)
		(ce && byte_done && !sending) |=> receive_done_flag && !cmd.recv)
		else $error("receive completion not reported");
	a_nack_recorded: assert property (@(posedge clk) disable iff (!nrst)
		(ce && byte_done && sending) |=>
		nack_seen == $past(master_serial_data_pin_i))
		else $error("acknowledge status not recorded");
	a_overrun_flag: assert property (@(posedge clk) disable iff (!nrst)
		(ce && byte_done && !sending && rx_full) |=>
		events.overrun && rx_buf == $past(rx_buf))
		else $error("overrun not flagged or byte overwritten");
	a_underrun_flag: assert property (@(posedge clk) disable iff (!nrst)
		(ce && launch && cmd.send && !tx_full) |=> events.underrun)
		else $error("underrun not flagged");
	a_irq_masked: assert property (@(posedge clk) disable iff (!nrst)
		irq |-> $past(top_irq_en) && $past(|(events & evt_mask)))
		else $error("interrupt raised while masked");
	a_busy_cmd_held: assert property (@(posedge clk) disable iff (!nrst)
		(ce && state != ST_IDLE && !tick && enabled) |=> $stable(cmd))
		else $error("command changed during a segment");

	c_start_done: cover property (@(posedge clk) disable iff (!nrst)
		start_done);
	c_tx_nack: cover property (@(posedge clk) disable iff (!nrst)
		byte_done && sending && master_serial_data_pin_i);
	c_rx_done: cover property (@(posedge clk) disable iff (!nrst)
		byte_done && !sending);
	c_stop_done: cover property (@(posedge clk) disable iff (!nrst)
		stop_done);
endmodule : scim_i2c_master
`default_nettype wire

// ### bench/scim_i2c_slave.sv
`default_nettype none
// Behavioural target on the two-wire bus; acks, answers reads, logs bytes
module scim_i2c_slave (
	input wire logic scl,
	input wire logic sda,
	input wire logic nack_cfg,
	input wire logic [7:0] rd_data,
	output logic sda_oe,
	output logic [7:0] last_byte,
	output logic mack
);
	timeunit 1ns;
	timeprecision 1ps;
	int bitn;
	logic rd;
	logic first;
	logic [7:0] sh;
	logic [7:0] tx;
	initial begin
		sda_oe = 1'b0;
		bitn = 0;
		rd = 1'b0;
		first = 1'b1;
		sh = 8'h00;
		tx = 8'h00;
		last_byte = 8'h00;
		mack = 1'b0;
	end
	// Data edge with clock high frames a transfer; no arbitration here
	always @(sda) begin
		if (scl === 1'b1) begin
			bitn = 0;
			rd = 1'b0;
			first = 1'b1;
			sda_oe = 1'b0;
		end
	end
	// Sample at clock rise; ninth bit of a read is the master's answer
	always @(posedge scl) begin
		if (bitn < 8)
			sh = {sh[6:0], sda};
		else if (rd)
			mack = ~sda;
		bitn = bitn + 1;
	end
	// Only ever pull low, changed while clock is low
	always @(negedge scl) begin
		if (bitn == 8) begin
			last_byte = sh;
			sda_oe = rd ? 1'b0 : ~nack_cfg;
			if (first) begin
				rd = sh[0];
				mack = ~nack_cfg;
			end
			first = 1'b0;
		end else if (bitn == 9) begin
			bitn = 0;
			tx = rd_data;
			sda_oe = rd & mack & ~rd_data[7];
		end else if (rd && mack && bitn > 0) begin
			sda_oe = ~tx[7 - bitn];
		end
	end
endmodule : scim_i2c_slave
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb;
	import scim_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, cyc, stb, we, top_en, slv_nack, ack, irq;
	logic scl_o, scl_oe, sda_o, sda_oe, s_oe, mack;
	logic [5:0] adr;
	logic [31:0] dat, dat_o, q, seed;
	logic [7:0] rd_data, last_byte, tx_b, rx_b;
	wire logic scl_w;
	wire logic sda_w;
	int miscompares, comparisons, hi_cnt, ev, st, tx_full, rx_full, ack_sel, h0;
	logic [5:0] offs[9] = '{OFS_MODE, OFS_RATE_LIN, OFS_RATE_EXP, OFS_CMD,
		OFS_ACK_CTRL, OFS_STATUS, OFS_EVENTS, OFS_EVT_MASK, 6'h3C};
	int lins[5] = '{0, 14, 15, 14, 0};
	int exps[5] = '{0, 3, 1, 1, 0};
	logic [3:0] ill[4] = '{4'h3, 4'h6, 4'hC, 4'h9};
	// Pull-ups: a released line reads high
	assign scl_w = ~scl_oe;
	assign sda_w = ~(sda_oe | s_oe);
	scim_i2c_master u_scim_i2c_master (.clk(clk), .nrst(nrst), .ce(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.top_irq_en(top_en), .irq(irq), .master_serial_clock_pin_i(scl_w),
		.master_serial_clock_pin_o(scl_o), .master_serial_clock_pin_oe(scl_oe),
		.master_serial_data_pin_i(sda_w), .master_serial_data_pin_o(sda_o),
		.master_serial_data_pin_oe(sda_oe));
	scim_i2c_slave u_scim_i2c_slave (.scl(scl_w), .sda(sda_w),
		.nack_cfg(slv_nack), .rd_data(rd_data), .sda_oe(s_oe),
		.last_byte(last_byte), .mack(mack));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Clock-high time, used to measure the bit rate
	always @(posedge clk) begin
		if (scl_w === 1'b1) hi_cnt <= hi_cnt + 1;
		if (nrst && (scl_o !== 1'b0 || sda_o !== 1'b0))
			check("line_driven_high", 1, 0);
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic check(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test
	// One classic cycle; waits for ack under a bound, read data into q
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic put(input logic [7:0] b);
		wb(1'b1, OFS_DATA, {24'h0, b});
		tx_b = b;
		tx_full = 1;
	endtask : put
	// Launch a segment, poll until done, compare against the model
	task automatic seg(input int b, input logic intr);
		int n;
		wb(1'b1, OFS_CMD, 32'h1 << b);
		if (intr) wb(1'b1, OFS_CMD, 32'h8);
		n = 0;
		do begin
			wb(1'b0, OFS_CMD, 32'h0);
			n++;
		end while (q[3:0] !== 4'h0 && n < 2000);
		if (n >= 2000) begin
			miscompares++;
			finish_test();
		end
		if (b == 1) begin
			ev |= 2 | (slv_nack ? 8 : 0) | (tx_full ? 0 : 32);
			st = (st & 14) | 2 | int'(slv_nack);
			tx_full = 0;
			check("slave_byte", last_byte, tx_b);
		end else if (b == 2) begin
			ev |= 4 | (rx_full ? 16 : 0);
			if (rx_full == 0) rx_b = rd_data;
			rx_full = 1;
			st |= 4;
			check("master_ack", mack, ack_sel);
		end else begin
			ev |= 1;
			st |= 8;
		end
		if (intr) check("held_scl", scl_w, 0);
		wb(1'b0, OFS_STATUS, 32'h0);
		check("status", q, st);
		wb(1'b0, OFS_EVENTS, 32'h0);
		check("events", q, ev);
	endtask : seg
	initial begin
		#4000000;
		miscompares++;
		finish_test();
	end
	initial begin
		{nrst, cyc, stb, we, top_en, slv_nack} = 6'h00;
		{adr, dat, rd_data, ack_sel} = '0;
		seed = 32'h0000_000E;
		{ev, st, tx_full, rx_full, tx_b, rx_b} = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		foreach (offs[i]) begin
			wb(1'b0, offs[i], 32'h0);
			check("reset_value", q, 0);
		end
		$display("test reset_values done");
		// Other modes must leave the lines alone
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, OFS_MODE, 32'h0);
			wb(1'b1, OFS_MODE, 32'hFFFC | m);
			wb(1'b0, OFS_MODE, 32'h0);
			check("mode", q, m);
			if (m < 3) begin
				wb(1'b1, OFS_CMD, 32'h1);
				repeat (20) @(posedge clk);
				check("idle_lines", {scl_w, sda_w}, 2'b11);
				wb(1'b1, OFS_CMD, 32'h0);
			end
		end
		foreach (ill[i]) begin
			wb(1'b1, OFS_CMD, {28'h0, ill[i]});
			repeat (20) @(posedge clk);
			wb(1'b0, OFS_CMD, 32'h0);
			check("illegal_cmd", q, ill[i]);
			check("illegal_lines", {scl_w, sda_w}, 2'b11);
			wb(1'b1, OFS_CMD, 32'h0);
		end
		$display("test modes done");
		// Rate settings; the last pass uses a ten-bit address
		foreach (lins[i]) begin
			wb(1'b1, OFS_RATE_LIN, lins[i]);
			wb(1'b1, OFS_RATE_EXP, exps[i]);
			seg(0, 1'b0);
			// Sized casts keep the random address inside its field
			put((i == 4) ? {5'h1E, 2'(xs()), 1'b0}
				: {7'(xs()), 1'b0});
			h0 = hi_cnt;
			seg(1, 1'b0);
			h0 = hi_cnt - h0;
			check("scl_high", h0, 9 * ((lins[i] + 1) << exps[i]));
			if (i == 4) begin
				put(8'(xs()));
				seg(1, 1'b0);
			end
			seg(3, 1'b0);
		end
		$display("test rates done");
		slv_nack = 1'b1;
		seg(0, 1'b0);
		put({7'(xs()), 1'b0});
		seg(1, 1'b0);
		slv_nack = 1'b0;
		wb(1'b1, OFS_EVT_MASK, 32'h8);
		check("irq_top_off", irq, 0);
		top_en <= 1'b1;
		repeat (2) @(posedge clk);
		check("irq_on", irq, 1);
		put(8'(xs()));
		seg(1, 1'b1);
		seg(1, 1'b0);
		seg(3, 1'b0);
		wb(1'b1, OFS_EVENTS, 32'h3F);
		ev = 0;
		// The registered interrupt trails the clear by one cycle
		@(posedge clk);
		check("irq_cleared", irq, 0);
		$display("test nack_irq_underrun done");
		rd_data = 8'(xs());
		seg(0, 1'b0);
		put({7'(xs()), 1'b1});
		seg(1, 1'b0);
		ack_sel = 1;
		wb(1'b1, OFS_ACK_CTRL, 32'h1);
		seg(2, 1'b0);
		ack_sel = 0;
		wb(1'b1, OFS_ACK_CTRL, 32'h0);
		seg(2, 1'b0);
		wb(1'b0, OFS_DATA, 32'h0);
		check("rx_data", q, rx_b);
		rx_full = 0;
		seg(3, 1'b0);
		$display("test read_overrun done");
		finish_test();
	end
endmodule : tb
`default_nettype wire
